// *** dv/pro_raster_opts_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module pro_raster_opts_bench;
    import pro_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    localparam logic signed [31:0] Z0 = 32'sh0010_0000;
    localparam logic [31:0]        AC = 32'hC0C0_0001;
    localparam logic [31:0]        AV = 32'hA0A0_0002;
    logic               core_clk, rst_n, ctl_wr, ctl_aa, slow, done_seen;
    logic [2:0]         ctl_ofs_en;
    logic               set_fill_style_wr, face_cull_select_wr;
    logic [1:0]         set_fill_style_face, set_fill_style_mode;
    logic [1:0]         face_cull_select_sel;
    logic               set_depth_bias_wr, cull_enable, depth_is_float;
    logic signed [15:0] set_depth_bias_factor, set_depth_bias_units;
    logic               point_aa_enable, line_aa_enable;
    logic               ms_enable, sample_buffers_one, prim_done, cmd_error;
    logic               prim_valid, prim_ready, frag_in_valid, frag_in_ready;
    logic               frag_out_valid, frag_out_ready, sub_valid, sub_ready;
    pro_prim_t          prim, pp;
    pro_frag_in_t       frag_in;
    pro_frag_out_t      frag_out;
    pro_sub_t           sub;
    pro_state_t         state;
    int                 err_total, total_checks, m, k, i;

    pro_raster_opts dut_u (.*);
    pro_sink sink_u (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Pulse is one cycle wide; latch it so slow polling cannot miss it
    always @(posedge core_clk) if (prim_done === 1'b1) done_seen <= 1'b1;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        summarize();
    endtask
    task automatic cyc();
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [3:0] w, input logic [31:0] d);
        cyc();
        {set_fill_style_face, set_fill_style_mode} = d[3:0];
        face_cull_select_sel = d[1:0];
        {set_depth_bias_factor, set_depth_bias_units} = d;
        {ctl_aa, ctl_ofs_en} = d[3:0];
        {set_fill_style_wr, face_cull_select_wr, set_depth_bias_wr, ctl_wr} = w;
        cyc();
        {set_fill_style_wr, face_cull_select_wr, set_depth_bias_wr, ctl_wr} = 0;
    endtask
    task automatic send_prim(input pro_prim_t p);
        int i;
        prim = p;
        prim_valid = 1'b1;
        for (i = 0; i < 40 && prim_ready !== 1'b1; i++) cyc();
        if (i == 40) hang();
        cyc();
        prim_valid = 1'b0;
    endtask
    task automatic put_frag(input pro_frag_in_t f);
        int i;
        cyc();
        frag_in = f;
        frag_in_valid = 1'b1;
        for (i = 0; i < 40 && frag_in_ready !== 1'b1; i++) cyc();
        if (i == 40) hang();
        cyc();
        frag_in_valid = 1'b0;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 40 && done_seen !== 1'b1; i++) cyc();
        if (i == 40) hang();
        done_seen = 1'b0;
    endtask
    task automatic expect_out(input logic emit, input pro_frag_out_t e,
                              input logic [1:0] ck);
        int i;
        for (i = 0; i < 20 && !(frag_out_valid === 1'b1 &&
             frag_out_ready === 1'b1); i++) cyc();
        chk(frag_out_valid, emit);
        if (emit) begin
            if (i == 20) hang();
            chk({frag_out.z, frag_out.attr}, {e.z, e.attr});
            chk({frag_out.x, frag_out.y}, {e.x, e.y});
            if (ck[0]) chk(frag_out.cov_mask, e.cov_mask);
            if (ck[1]) chk(frag_out.cov_area, e.cov_area);
            cyc();
        end
    endtask
    function automatic pro_prim_t mkp(input logic fr, input logic [7:0] ze);
        mkp.front = fr;
        mkp.v[0] = {16'h0010, 16'h0020, 32'sh0010_0000};
        mkp.v[1] = {16'h0030, 16'h0021, 32'sh0020_0000};
        mkp.v[2] = {16'h0012, 16'h0040, 32'sh0030_0000};
        mkp.dzdx = 32'sh0010_0000;
        mkp.dzdy = 32'shFFE0_0000;
        mkp.zexp = ze;
    endfunction
    function automatic pro_frag_in_t mkf(input logic c, input logic f,
        input logic [7:0] a, input logic [7:0] s, input logic [31:0] z);
        mkf = {16'h0010, 16'h0020, c, f, a, s, z, AC, AV, 1'b1};
    endfunction
    function automatic pro_frag_out_t mko(input logic [7:0] s,
        input logic [7:0] a, input logic [31:0] z, input logic [31:0] t);
        mko = {16'h0010, 16'h0020, s, a, z, t};
    endfunction
    task automatic run_fill(input logic fr, input logic [7:0] ze,
        input pro_frag_in_t f, input logic emit, input pro_frag_out_t e,
        input logic [1:0] ck);
        send_prim(mkp(fr, ze));
        put_frag(f);
        expect_out(emit, e, ck);
        wait_done();
    endtask

    initial begin
        {ctl_wr, ctl_aa, ctl_ofs_en, set_fill_style_wr, face_cull_select_wr} = 0;
        {set_fill_style_face, set_fill_style_mode, face_cull_select_sel} = 0;
        {set_depth_bias_wr, set_depth_bias_factor, set_depth_bias_units} = 0;
        {cull_enable, point_aa_enable, line_aa_enable, ms_enable} = 4'h0;
        {sample_buffers_one, depth_is_float, prim_valid, frag_in_valid} = 4'h0;
        {slow, done_seen, prim, frag_in, rst_n} = 0;
        pp = mkp(1'b1, 8'h00);
        repeat (3) cyc();
        rst_n = 1'b1;
        chk(state, {PRO_FILL_AREA, PRO_FACE_BACK, 4'h0, 32'h0});
        wr(4'h8, {PRO_FACE_FRONT, PRO_FILL_POINT});
        chk({cmd_error, state.fill}, {1'b1, PRO_FILL_AREA});
        wr(4'h8, {PRO_FACE_BOTH, 2'h3});
        chk({cmd_error, state.fill}, {1'b1, PRO_FILL_AREA});
        wr(4'h4, 32'h3);
        chk({cmd_error, state.cull_sel}, {1'b1, PRO_FACE_BACK});
        for (m = 0; m < 3; m++) begin
            wr(4'h8, {PRO_FACE_BOTH, m[1:0]});
            chk({cmd_error, state.fill}, {1'b0, m[1:0]});
        end
        wr(4'h2, 32'h0100_0000);
        chk({state.factor, state.units}, 32'h0100_0000);
        wr(4'h1, 32'h9);
        {point_aa_enable, ms_enable, sample_buffers_one, slow} = 4'hF;
        for (m = 0; m < 2; m++) begin
            wr(4'h8, {PRO_FACE_BOTH, m[1:0]});
            send_prim(pp);
            for (k = 0; k < 3; k++) begin
                for (i = 0; i < 40 && (sub_valid & sub_ready) !== 1'b1; i++)
                    cyc();
                if (i == 40) hang();
                chk(sub.is_line, m[0]);
                chk(sub.va, pp.v[k]);
                if (m == 1) chk(sub.vb, pp.v[(k + 1) % 3]);
                chk({sub.smooth, sub.multisample}, {~m[0], 1'b1});
                chk(sub.ofs_en, !m[0]);
                if (m == 0) chk(sub.ofs, 32'sh0020_0000);
                cyc();
            end
            wait_done();
        end
        cull_enable = 1'b1;
        slow = 1'b0;
        wr(4'h4, PRO_FACE_BOTH);
        wr(4'h8, {PRO_FACE_BOTH, PRO_FILL_POINT});
        send_prim(pp);
        wait_done();
        chk(sub_valid, 1'b0);
        wr(4'h8, {PRO_FACE_BOTH, PRO_FILL_AREA});
        wr(4'h1, 32'h4);
        run_fill(1, 0, mkf(1, 1, 8'hFF, 8'h05, Z0), 0, '0, 0);
        wr(4'h4, PRO_FACE_BACK);
        slow = 1'b1;
        run_fill(1, 0, mkf(1, 1, 8'hFF, 8'h05, Z0), 1,
                 mko(8'h05, 8'hFF, 32'h0030_0000, AC), 3);
        run_fill(1, 0, mkf(1, 1, 8'hFF, 8'h00, Z0), 0, '0, 0);
        run_fill(0, 0, mkf(1, 1, 8'hFF, 8'h05, Z0), 0, '0, 0);
        run_fill(1, 0, mkf(1, 1, 8'hFF, 8'h81, 32'h00F0_0000), 1,
                 mko(8'h81, 8'hFF, PRO_DEPTH_ONE, AC), 3);
        cull_enable = 1'b0;
        {ms_enable, slow} = 2'h0;
        wr(4'h1, 32'h8);
        run_fill(0, 0, mkf(1, 0, 8'h00, 8'hFF, Z0), 0, '0, 0);
        run_fill(0, 0, mkf(0, 0, 8'h40, 8'h00, Z0), 1,
                 mko(8'h00, 8'h40, Z0, AV), 2);
        run_fill(1, 0, mkf(1, 1, 8'hFF, 8'h00, Z0), 1,
                 mko(8'h00, 8'hFF, Z0, AC), 2);
        wr(4'h1, 32'h4);
        run_fill(1, 0, mkf(0, 0, 8'h40, 8'h0F, Z0), 0, '0, 0);
        wr(4'h2, 32'h0000_0200);
        run_fill(1, 0, mkf(1, 0, 8'h40, 8'h00, Z0), 1,
                 mko(8'hFF, 8'h00, Z0 + 2, AC), 1);
        depth_is_float = 1'b1;
        run_fill(1, 0, mkf(1, 0, 8'h40, 8'h00, Z0), 1,
                 mko(8'hFF, 8'h00, Z0 + 4, AC), 1);
        depth_is_float = 1'b0;
        wr(4'h2, 32'hFF00_0000);
        run_fill(1, 0, mkf(1, 0, 8'h40, 8'h00, Z0), 1,
                 mko(8'hFF, 8'h00, 32'h0, AC), 1);
        summarize();
    end
endmodule

`default_nettype wire

// *** dv/pro_raster_opts_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module pro_raster_opts_mon
    import pro_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire logic          set_fill_style_wr,
    input wire logic [1:0]    set_fill_style_face,
    input wire logic [1:0]    set_fill_style_mode,
    input wire logic          face_cull_select_wr,
    input wire logic [1:0]    face_cull_select_sel,
    input wire logic          cull_enable,
    input wire logic          ms_enable,
    input wire logic          sample_buffers_one,
    input wire logic          prim_valid,
    input wire logic          prim_ready,
    input wire logic          frag_out_valid,
    input wire logic          frag_out_ready,
    input wire pro_frag_out_t frag_out,
    input wire logic          sub_valid,
    input wire logic          prim_done,
    input wire logic          cmd_error,
    input wire pro_state_t    state
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_rst_state;
        $rose(rst_n) |-> state == {PRO_FILL_AREA, PRO_FACE_BACK, 4'h0, 32'h0};
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("state not at reset values");

    property p_fill_ok;
        set_fill_style_wr && set_fill_style_face == PRO_FACE_BOTH &&
        set_fill_style_mode != 2'h3 |=> state.fill == $past(set_fill_style_mode);
    endproperty
    a_fill_ok: assert property (p_fill_ok)
        else $error("fill style not replaced");

    property p_fill_bad;
        set_fill_style_wr && (set_fill_style_face != PRO_FACE_BOTH ||
        set_fill_style_mode == 2'h3) |=> cmd_error && $stable(state.fill);
    endproperty
    a_fill_bad: assert property (p_fill_bad)
        else $error("bad fill write not refused");

    property p_cull_wr;
        face_cull_select_wr |=> (face_cull_select_sel == 2'h3) ?
            (cmd_error && $stable(state.cull_sel)) :
            (state.cull_sel == $past(face_cull_select_sel));
    endproperty
    a_cull_wr: assert property (p_cull_wr)
        else $error("cull select write wrong");

    property p_frag_hold;
        frag_out_valid && !frag_out_ready |=> frag_out_valid && $stable(frag_out);
    endproperty
    a_frag_hold: assert property (p_frag_hold)
        else $error("fragment dropped while stalled");

    property p_clamp;
        frag_out_valid |-> !frag_out.z[31] && frag_out.z <= PRO_DEPTH_ONE;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("depth outside unit range");

    property p_ms_cov;
        frag_out_valid && ms_enable && sample_buffers_one |->
            frag_out.cov_area == PRO_AREA_FULL && frag_out.cov_mask != 8'h00;
    endproperty
    a_ms_cov: assert property (p_ms_cov)
        else $error("multisample fragment without samples");

    property p_cull_pt;
        prim_valid && prim_ready && cull_enable &&
        state.cull_sel == PRO_FACE_BOTH && state.fill != PRO_FILL_AREA
        |=> prim_done && !sub_valid;
    endproperty
    a_cull_pt: assert property (p_cull_pt)
        else $error("culled primitive not dropped");
endmodule

bind pro_raster_opts pro_raster_opts_mon mon_u (.*);

`default_nettype wire

// *** dv/pro_sink.sv ***
`timescale 1ns/10ps
`default_nettype none

module pro_sink (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      frag_out_ready,
    output logic      sub_ready
);
    // ------------------------------------------------------------
    // Downstream acceptance
    // ------------------------------------------------------------
    logic phase_ff;

    // Registered so ready only moves just after a rising edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_ff       <= 1'b0;
            frag_out_ready <= 1'b0;
            sub_ready      <= 1'b0;
        end else begin
            phase_ff       <= ~phase_ff;
            frag_out_ready <= !slow || phase_ff;
            sub_ready      <= !slow || !phase_ff;
        end
    end
endmodule

`default_nettype wire

// *** rtl/pro_pkg.sv ***
package pro_pkg;

    // ------------------------------------------------------------
    // Depth number format and sampling
    // ------------------------------------------------------------
    localparam int                 PRO_DEPTH_FRAC = 24;
    localparam logic signed [31:0] PRO_DEPTH_ONE  = 32'sh0100_0000;
    localparam int                 PRO_SAMPLES    = 8;
    localparam int                 PRO_BIAS_FRAC  = 8;
    localparam int                 PRO_R_SHIFT_MAX = 30;
    localparam logic [7:0]         PRO_AREA_FULL  = 8'hFF;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PRO_FILL_POINT = 2'h0,
        PRO_FILL_LINE  = 2'h1,
        PRO_FILL_AREA  = 2'h2
    } pro_fill_t;

    typedef enum logic [1:0] {
        PRO_FACE_FRONT = 2'h0,
        PRO_FACE_BACK  = 2'h1,
        PRO_FACE_BOTH  = 2'h2
    } pro_face_t;

    localparam int PRO_OFS_POINT = 0;
    localparam int PRO_OFS_LINE  = 1;
    localparam int PRO_OFS_FILL  = 2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam pro_fill_t          PRO_RST_FILL   = PRO_FILL_AREA;
    localparam pro_face_t          PRO_RST_CULL   = PRO_FACE_BACK;
    localparam logic               PRO_RST_AA     = 1'b0;
    localparam logic [2:0]         PRO_RST_OFS_EN = 3'h0;
    localparam logic signed [15:0] PRO_RST_FACTOR = 16'sh0000;
    localparam logic signed [15:0] PRO_RST_UNITS  = 16'sh0000;
    localparam logic [1:0]         PRO_RST_IDX    = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]        x;
        logic [15:0]        y;
        logic signed [31:0] z;
    } pro_vtx_t;

    typedef struct packed {
        logic               front;
        pro_vtx_t [2:0]     v;
        logic signed [31:0] dzdx;
        logic signed [31:0] dzdy;
        logic signed [7:0]  zexp;
    } pro_prim_t;

    typedef struct packed {
        logic [15:0]            x;
        logic [15:0]            y;
        logic                   center_in;
        logic                   full_in;
        logic [7:0]             area_cov;
        logic [PRO_SAMPLES-1:0] smask;
        logic signed [31:0]     z;
        logic [31:0]            attr_ctr;
        logic [31:0]            attr_avg;
        logic                   last;
    } pro_frag_in_t;

    typedef struct packed {
        logic [15:0]            x;
        logic [15:0]            y;
        logic [PRO_SAMPLES-1:0] cov_mask;
        logic [7:0]             cov_area;
        logic signed [31:0]     z;
        logic [31:0]            attr;
    } pro_frag_out_t;

    typedef struct packed {
        logic               is_line;
        pro_vtx_t           va;
        pro_vtx_t           vb;
        logic               smooth;
        logic               multisample;
        logic               ofs_en;
        logic signed [31:0] ofs;
    } pro_sub_t;

    typedef struct packed {
        pro_fill_t          fill;
        pro_face_t          cull_sel;
        logic               aa;
        logic [2:0]         ofs_en;
        logic signed [15:0] factor;
        logic signed [15:0] units;
    } pro_state_t;

endpackage

// *** rtl/pro_raster_opts.sv ***
`timescale 1ns/10ps
`default_nettype none

module pro_raster_opts
    import pro_pkg::*;
#(
    parameter int                 FLOAT_MANT_BITS = 23,
    parameter logic signed [31:0] FIXED_R         = 32'sh0000_0001
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               ctl_wr,
    input  wire logic               ctl_aa,
    input  wire logic [2:0]         ctl_ofs_en,
    input  wire logic               set_fill_style_wr,
    input  wire logic [1:0]         set_fill_style_face,
    input  wire logic [1:0]         set_fill_style_mode,
    input  wire logic               face_cull_select_wr,
    input  wire logic [1:0]         face_cull_select_sel,
    input  wire logic               set_depth_bias_wr,
    input  wire logic signed [15:0] set_depth_bias_factor,
    input  wire logic signed [15:0] set_depth_bias_units,
    input  wire logic               cull_enable,
    input  wire logic               point_aa_enable,
    input  wire logic               line_aa_enable,
    input  wire logic               ms_enable,
    input  wire logic               sample_buffers_one,
    input  wire logic               depth_is_float,
    input  wire logic               prim_valid,
    output logic                    prim_ready,
    input  wire pro_prim_t          prim,
    input  wire logic               frag_in_valid,
    output logic                    frag_in_ready,
    input  wire pro_frag_in_t       frag_in,
    output logic                    frag_out_valid,
    input  wire logic               frag_out_ready,
    output pro_frag_out_t           frag_out,
    output logic                    sub_valid,
    input  wire logic               sub_ready,
    output pro_sub_t                sub,
    output logic                    prim_done,
    output logic                    cmd_error,
    output pro_state_t              state
);
    import pro_pkg::*;

    // ------------------------------------------------------------
    // Rasterization state
    // ------------------------------------------------------------
    pro_state_t state_ff;
    pro_state_t nxt_state;
    logic       err_ff;
    logic       nxt_err;

    always_comb begin
        nxt_state = state_ff;
        nxt_err   = 1'b0;
        if (ctl_wr) begin
            nxt_state.aa     = ctl_aa;
            nxt_state.ofs_en = ctl_ofs_en;
        end
        if (set_fill_style_wr) begin
            if (set_fill_style_face == PRO_FACE_BOTH &&
                set_fill_style_mode != 2'h3) begin
                nxt_state.fill = pro_fill_t'(set_fill_style_mode);
            end else begin
                nxt_err = 1'b1;
            end
        end
        if (face_cull_select_wr) begin
            if (face_cull_select_sel != 2'h3) begin
                nxt_state.cull_sel = pro_face_t'(face_cull_select_sel);
            end else begin
                nxt_err = 1'b1;
            end
        end
        if (set_depth_bias_wr) begin
            nxt_state.factor = set_depth_bias_factor;
            nxt_state.units  = set_depth_bias_units;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff.fill     <= PRO_RST_FILL;
            state_ff.cull_sel <= PRO_RST_CULL;
            state_ff.aa       <= PRO_RST_AA;
            state_ff.ofs_en   <= PRO_RST_OFS_EN;
            state_ff.factor   <= PRO_RST_FACTOR;
            state_ff.units    <= PRO_RST_UNITS;
            err_ff            <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            err_ff   <= nxt_err;
        end
    end

    assign state     = state_ff;
    assign cmd_error = err_ff;

    // ------------------------------------------------------------
    // Per-polygon depth offset
    // ------------------------------------------------------------
    logic signed [31:0] abs_dx;
    logic signed [31:0] abs_dy;
    logic signed [31:0] slope;
    logic signed [63:0] r_val;
    logic signed [63:0] o_sum;
    logic signed [31:0] o_val;
    logic               visible;
    int                 r_sh;

    always_comb begin
        abs_dx = prim.dzdx[31] ? -prim.dzdx : prim.dzdx;
        abs_dy = prim.dzdy[31] ? -prim.dzdy : prim.dzdy;
        slope  = (abs_dx > abs_dy) ? abs_dx : abs_dy;
        r_sh   = int'(prim.zexp) - FLOAT_MANT_BITS + PRO_DEPTH_FRAC;
        if (!depth_is_float) begin
            r_val = 64'(FIXED_R);
        end else if (r_sh <= 0) begin
            r_val = 64'sd1;
        end else if (r_sh > PRO_R_SHIFT_MAX) begin
            r_val = 64'sd1 <<< PRO_R_SHIFT_MAX;
        end else begin
            r_val = 64'sd1 <<< r_sh;
        end
        o_sum = (64'(slope) * 64'(state_ff.factor) +
                 r_val * 64'(state_ff.units)) >>> PRO_BIAS_FRAC;
        if (o_sum > 64'(PRO_DEPTH_ONE)) begin
            o_val = PRO_DEPTH_ONE;
        end else if (o_sum < -64'(PRO_DEPTH_ONE)) begin
            o_val = -PRO_DEPTH_ONE;
        end else begin
            o_val = o_sum[31:0];
        end
        visible = !cull_enable ||
                  (prim.front  && state_ff.cull_sel == PRO_FACE_BACK) ||
                  (!prim.front && state_ff.cull_sel == PRO_FACE_FRONT);
    end

    function automatic logic signed [31:0] clamp_z(
        input logic signed [32:0] v
    );
        logic signed [31:0] r;
        if (v < 33'sd0) begin
            r = 32'sh0000_0000;
        end else if (v > 33'(PRO_DEPTH_ONE)) begin
            r = PRO_DEPTH_ONE;
        end else begin
            r = v[31:0];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Primitive sequencing
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PRO_ST_IDLE  = 4'b0001,
        PRO_ST_SUB   = 4'b0010,
        PRO_ST_FILL  = 4'b0100,
        PRO_ST_DRAIN = 4'b1000
    } pro_st_t;

    pro_st_t            st_ff;
    pro_st_t            nxt_st;
    pro_prim_t          prim_ff;
    pro_prim_t          nxt_prim;
    pro_fill_t          style_ff;
    pro_fill_t          nxt_style;
    logic               aa_ff;
    logic               nxt_aa;
    logic [2:0]         ofs_en_ff;
    logic [2:0]         nxt_ofs_en;
    logic signed [31:0] ofs_ff;
    logic signed [31:0] nxt_ofs;
    logic [1:0]         idx_ff;
    logic [1:0]         nxt_idx;
    logic               done_ff;
    logic               nxt_done;
    logic               fo_valid_ff;
    logic               nxt_fo_valid;
    pro_frag_out_t      fo_ff;
    pro_frag_out_t      nxt_fo;
    logic               ms;
    logic               emit;
    logic [1:0]         idx_b;

    assign ms            = ms_enable && sample_buffers_one;
    assign prim_ready    = (st_ff == PRO_ST_IDLE);
    assign frag_in_ready = (st_ff == PRO_ST_DRAIN) ||
                           ((st_ff == PRO_ST_FILL) &&
                            (!fo_valid_ff || frag_out_ready));
    assign sub_valid     = (st_ff == PRO_ST_SUB);
    assign idx_b         = (idx_ff == 2'h2) ? 2'h0 : idx_ff + 2'h1;

    always_comb begin
        sub.is_line     = (style_ff == PRO_FILL_LINE);
        sub.va          = prim_ff.v[idx_ff];
        sub.vb          = prim_ff.v[idx_b];
        sub.smooth      = sub.is_line ? line_aa_enable
                                      : point_aa_enable;
        sub.multisample = ms;
        sub.ofs_en      = sub.is_line ? ofs_en_ff[PRO_OFS_LINE]
                                      : ofs_en_ff[PRO_OFS_POINT];
        sub.ofs         = ofs_ff;
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_prim     = prim_ff;
        nxt_style    = style_ff;
        nxt_aa       = aa_ff;
        nxt_ofs_en   = ofs_en_ff;
        nxt_ofs      = ofs_ff;
        nxt_idx      = idx_ff;
        nxt_done     = 1'b0;
        nxt_fo_valid = fo_valid_ff && !frag_out_ready;
        nxt_fo       = fo_ff;
        emit         = 1'b0;
        unique case (st_ff)
            PRO_ST_IDLE: begin
                if (prim_valid) begin
                    nxt_prim   = prim;
                    nxt_style  = state_ff.fill;
                    nxt_aa     = state_ff.aa;
                    nxt_ofs_en = state_ff.ofs_en;
                    nxt_ofs    = o_val;
                    nxt_idx    = PRO_RST_IDX;
                    // Culling decided before the style takes effect
                    if (state_ff.fill != PRO_FILL_AREA) begin
                        nxt_st = visible ? PRO_ST_SUB : PRO_ST_IDLE;
                        nxt_done = !visible;
                    end else begin
                        nxt_st = visible ? PRO_ST_FILL
                                         : PRO_ST_DRAIN;
                    end
                end
            end
            PRO_ST_SUB: begin
                if (sub_ready) begin
                    nxt_idx = idx_b;
                    if (idx_ff == 2'h2) begin
                        nxt_st   = PRO_ST_IDLE;
                        nxt_done = 1'b1;
                    end
                end
            end
            PRO_ST_FILL: begin
                if (frag_in_valid && frag_in_ready) begin
                    if (ms) begin
                        emit = |frag_in.smask;
                    end else if (aa_ff) begin
                        emit = (frag_in.area_cov != 8'h00);
                    end else begin
                        emit = frag_in.center_in;
                    end
                    if (emit) begin
                        nxt_fo_valid    = 1'b1;
                        nxt_fo.x        = frag_in.x;
                        nxt_fo.y        = frag_in.y;
                        nxt_fo.cov_mask = ms ? frag_in.smask
                                             : {PRO_SAMPLES{1'b1}};
                        nxt_fo.cov_area = (!ms && aa_ff) ?
                                          frag_in.area_cov
                                          : PRO_AREA_FULL;
                        // Sample attributes come in per sample already
                        nxt_fo.attr     = (!ms && aa_ff && !frag_in.full_in)
                                          ? frag_in.attr_avg
                                          : frag_in.attr_ctr;
                        nxt_fo.z        = clamp_z(
                            33'(frag_in.z) +
                            (ofs_en_ff[PRO_OFS_FILL] ? 33'(ofs_ff)
                                                     : 33'sd0));
                    end
                    if (frag_in.last) begin
                        nxt_st   = PRO_ST_IDLE;
                        nxt_done = 1'b1;
                    end
                end
            end
            PRO_ST_DRAIN: begin
                // Culled polygon: fragments swallowed, none emitted
                if (frag_in_valid && frag_in.last) begin
                    nxt_st   = PRO_ST_IDLE;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_st = PRO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff       <= PRO_ST_IDLE;
            prim_ff     <= '0;
            style_ff    <= PRO_RST_FILL;
            aa_ff       <= PRO_RST_AA;
            ofs_en_ff   <= PRO_RST_OFS_EN;
            ofs_ff      <= 32'sh0000_0000;
            idx_ff      <= PRO_RST_IDX;
            done_ff     <= 1'b0;
            fo_valid_ff <= 1'b0;
            fo_ff       <= '0;
        end else begin
            st_ff       <= nxt_st;
            prim_ff     <= nxt_prim;
            style_ff    <= nxt_style;
            aa_ff       <= nxt_aa;
            ofs_en_ff   <= nxt_ofs_en;
            ofs_ff      <= nxt_ofs;
            idx_ff      <= nxt_idx;
            done_ff     <= nxt_done;
            fo_valid_ff <= nxt_fo_valid;
            fo_ff       <= nxt_fo;
        end
    end

    assign frag_out_valid = fo_valid_ff;
    assign frag_out       = fo_ff;
    assign prim_done      = done_ff;

endmodule

`default_nettype wire
